// ### rtl/lppl_pkg.sv
// Constants shared by the light pen position latch and its helpers.
// Assumes a 32-bit AHB-Lite register bus and an 8-bit beam counter pair.
package lppl_pkg;
    // Number of controller-port trigger lines
    localparam int LPPL_NTRIG = 4;
    // Byte offsets of the registers
    localparam logic [7:0] LPPL_OFS_COLUMN = 8'h00;
    localparam logic [7:0] LPPL_OFS_ROW = 8'h04;
    localparam logic [7:0] LPPL_OFS_GFX_CTRL = 8'h08;
    localparam logic [7:0] LPPL_OFS_IRQ_STS = 8'h0c;
    localparam logic [7:0] LPPL_OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] LPPL_OFS_TRIG_BASE = 8'h20;
    localparam logic [7:0] LPPL_TRIG_STRIDE = 8'h04;
    // Graphics control: trigger latch enable bit
    localparam int LPPL_LATCH_BIT = 2;
    // Interrupt event bits
    localparam int LPPL_NEV = 2;
    localparam int LPPL_EV_PEN = 0;
    localparam int LPPL_EV_TRIG = 1;
    // Reset values
    localparam logic LPPL_LATCH_RST = 1'b0;
    localparam logic [LPPL_NEV-1:0] LPPL_MASK_RST = 2'h0;
    localparam logic [LPPL_NEV-1:0] LPPL_STS_RST = 2'h0;
    // Bus answers
    localparam logic LPPL_HRESP_OKAY = 1'b0;
    localparam int LPPL_HTRANS_ACTIVE_BIT = 1;
endpackage

// ### rtl/lppl_sync.sv
// Two-stage synchroniser bank for asynchronous pins.
// Assumes one clock; the first stage feeds only the second.
`timescale 1ns/1ns
module lppl_sync
    import lppl_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } lppl_sync_state_t;

    lppl_sync_state_t s_r;
    lppl_sync_state_t s_nxt;

    always_comb begin
        s_nxt.meta = async_i;
        s_nxt.sync = s_r.meta;
        if (srst_i) begin
            s_nxt.meta = RST_VAL;
            s_nxt.sync = RST_VAL;
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    assign sync_o = s_r.sync;
endmodule

// ### rtl/lppl_trig_latch.sv
// Trigger register bank with optional sticky latching of activation.
// Assumes synchronised, active-high trigger activity on the input.
`timescale 1ns/1ns
module lppl_trig_latch
    import lppl_pkg::*;
#(
    parameter int N = 4
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [N-1:0] act_i,
    input wire logic latch_en_i,
    output logic [N-1:0] level_o,
    output logic rise_o
);
    typedef struct packed {
        logic [N-1:0] prev;
        logic [N-1:0] held;
        logic [N-1:0] level;
        logic rise;
    } lppl_tl_state_t;

    lppl_tl_state_t s_r;
    lppl_tl_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.prev = act_i;
        s_nxt.rise = |(act_i & ~s_r.prev);
        for (int i = 0; i < N; i++) begin
            // Held activation survives release while latching is on
            s_nxt.held[i] = latch_en_i & (s_r.held[i] | act_i[i]);
            // One enable serves every trigger
            s_nxt.level[i] = ~(act_i[i] | s_nxt.held[i]);
        end
        if (srst_i) begin
            s_nxt.prev = '0;
            s_nxt.held = '0;
            s_nxt.level = '1;
            s_nxt.rise = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    assign level_o = s_r.level;
    assign rise_o = s_r.rise;
endmodule

// ### rtl/lppl_light_pen.sv
// Light pen position latch with trigger registers, AHB-Lite slave.
// Assumes beam counters arrive on clk_i; trigger pins are asynchronous.
//
// Contract
// - Capture beam counters only on the edge into beam-sense assertion.
// - A held beam-sense input keeps the first capture, no recapture.
// - Captured column has color-clock resolution, values 0 to 227.
// - Captured row counts two-line units, 0-130 or 0-155.
// - Capture also in border and blanking; no visible-area gating.
// - Position registers hold indefinitely; vertical blank leaves them.
// - Reset leaves position registers unchanged; power-up value arbitrary.
// - Beam-sense is the combination of all wired port triggers.
// - Control bit 2 enables trigger latching for on-screen polling.
// - Pulses as short as 16 machine cycles are reliably registered.
// - Trigger register bits 1-7 zero; bit 0 is 1 when inactive.
// - Latching enable covers all triggers; latched activation persists.
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module lppl_light_pen
    import lppl_pkg::*;
#(
    parameter int NTRIG = LPPL_NTRIG
) (
    input wire logic clk_i,
    input wire logic srst_i,
    // Controller-port trigger pins, low while active
    input wire logic [NTRIG-1:0] trig_n_i,
    // Beam position counters of the video controller
    input wire logic [7:0] beam_column_i,
    input wire logic [7:0] beam_row_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic irq_o
);
    typedef struct packed {
        logic [7:0] column;
        logic [7:0] row;
        logic beam_prev;
        logic latch_en;
        logic [LPPL_NEV-1:0] sts;
        logic [LPPL_NEV-1:0] mask;
        logic pend;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] rdata;
        logic rdy;
        logic hresp;
        logic irq;
    } lppl_state_t;

    lppl_state_t s_r;
    lppl_state_t s_nxt;

    logic [NTRIG-1:0] trig_n_s;
    logic [NTRIG-1:0] trig_act;
    logic [NTRIG-1:0] trig_level;
    logic trig_rise;
    logic beam_sense;
    logic pen_edge;
    logic take;
    logic [LPPL_NEV-1:0] ev;
    logic [LPPL_NEV-1:0] clr;
    logic [31:0] rd_mux;

    // Two flops before any logic sees the pins
    lppl_sync #(
        .WIDTH(NTRIG),
        .RST_VAL({NTRIG{1'b1}})
    ) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i(trig_n_i),
        .sync_o(trig_n_s)
    );

    // At 8 ns a 16-cycle pulse spans many samples
    assign trig_act = ~trig_n_s;

    lppl_trig_latch #(
        .N(NTRIG)
    ) u_trig (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .act_i(trig_act),
        .latch_en_i(s_r.latch_en),
        .level_o(trig_level),
        .rise_o(trig_rise)
    );

    // Read multiplexer over current state
    always_comb begin
        rd_mux = 32'h0;
        case (s_r.paddr)
            LPPL_OFS_COLUMN: begin
                rd_mux[7:0] = s_r.column;
            end
            LPPL_OFS_ROW: begin
                rd_mux[7:0] = s_r.row;
            end
            LPPL_OFS_GFX_CTRL: begin
                rd_mux[LPPL_LATCH_BIT] = s_r.latch_en;
            end
            LPPL_OFS_IRQ_STS: begin
                rd_mux[LPPL_NEV-1:0] = s_r.sts;
            end
            LPPL_OFS_IRQ_MASK: begin
                rd_mux[LPPL_NEV-1:0] = s_r.mask;
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
        for (int i = 0; i < NTRIG; i++) begin
            if (s_r.paddr == 8'(LPPL_OFS_TRIG_BASE
                    + 8'(i) * LPPL_TRIG_STRIDE)) begin
                // Upper bits read zero
                rd_mux = {31'h0, trig_level[i]};
            end
        end
    end

    always_comb begin
        // Default hold keeps positions until the next edge
        s_nxt = s_r;
        clr = '0;
        // Any wired trigger drives the beam sense
        beam_sense = |trig_act;
        // Edge only, so a held line cannot recapture
        pen_edge = beam_sense & ~s_r.beam_prev;
        s_nxt.beam_prev = beam_sense;
        // No blanking or border gating on the capture
        if (pen_edge) begin
            s_nxt.column = beam_column_i;
            s_nxt.row = beam_row_i;
        end

        take = hsel_i & htrans_i[LPPL_HTRANS_ACTIVE_BIT] & hready_i;
        if (s_r.pend) begin
            s_nxt.pend = 1'b0;
            s_nxt.rdy = 1'b1;
            if (s_r.pwrite) begin
                case (s_r.paddr)
                    LPPL_OFS_GFX_CTRL: begin
                        s_nxt.latch_en = hwdata_i[LPPL_LATCH_BIT];
                    end
                    LPPL_OFS_IRQ_STS: begin
                        clr = hwdata_i[LPPL_NEV-1:0];
                    end
                    LPPL_OFS_IRQ_MASK: begin
                        s_nxt.mask = hwdata_i[LPPL_NEV-1:0];
                    end
                    default: begin
                        clr = '0;
                    end
                endcase
            end else begin
                s_nxt.rdata = rd_mux;
            end
        end else if (take) begin
            s_nxt.pend = 1'b1;
            s_nxt.pwrite = hwrite_i;
            s_nxt.paddr = haddr_i[7:0];
            s_nxt.rdy = 1'b0;
        end

        // Set wins over a simultaneous clear
        ev = '0;
        ev[LPPL_EV_PEN] = pen_edge;
        ev[LPPL_EV_TRIG] = trig_rise;
        s_nxt.sts = (s_r.sts & ~clr) | ev;
        s_nxt.hresp = LPPL_HRESP_OKAY;
        s_nxt.irq = |(s_nxt.sts & s_nxt.mask);

        if (srst_i) begin
            // Positions deliberately survive reset
            s_nxt.column = s_r.column;
            s_nxt.row = s_r.row;
            s_nxt.beam_prev = 1'b0;
            s_nxt.latch_en = LPPL_LATCH_RST;
            s_nxt.sts = LPPL_STS_RST;
            s_nxt.mask = LPPL_MASK_RST;
            s_nxt.pend = 1'b0;
            s_nxt.pwrite = 1'b0;
            s_nxt.paddr = 8'h00;
            s_nxt.rdata = 32'h0;
            s_nxt.rdy = 1'b1;
            s_nxt.hresp = LPPL_HRESP_OKAY;
            s_nxt.irq = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    assign hrdata_o = s_r.rdata;
    assign hreadyout_o = s_r.rdy;
    assign hresp_o = s_r.hresp;
    assign irq_o = s_r.irq;
endmodule

// ### testbench/lppl_pen_model.sv
// Light pen model: pulls selected trigger lines low for a set width.
// Assumes pulled-up trigger lines that idle high between pulses.
`timescale 1ns/1ns
module lppl_pen_model #(
    parameter int N = 4
) (
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic [N-1:0] sel_i,
    input wire logic [7:0] width_i,
    output logic [N-1:0] trig_n_o
);
    logic [7:0] cnt_r = 8'h00;
    always_ff @(posedge clk_i) begin
        if (fire_i) begin
            cnt_r <= width_i;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
    // Low while the beam is seen
    assign trig_n_o = (cnt_r != 8'h00) ? ~sel_i : '1;
endmodule

// ### testbench/lppl_light_pen_props.sv
// Port checker for the light pen position latch.
// Assumes the top's hready input is fed from its own hreadyout.
`timescale 1ns/1ns
module lppl_light_pen_props #(
    parameter int NTRIG = 4
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [NTRIG-1:0] trig_n_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    wire taken = hsel_i & htrans_i[1] & hready_i;
    logic wrote_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wrote_r <= 1'b0;
        end else begin
            wrote_r <= wrote_r | (taken & hwrite_i);
        end
    end
    property p_okay; hresp_o == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bad hresp");
    property p_wait; taken |=> !hreadyout_o ##1 hreadyout_o; endproperty
    a_wait: assert property (p_wait) else $error("bad wait state");
    property p_cause; $fell(hreadyout_o) |-> $past(taken); endproperty
    a_cause: assert property (p_cause) else $error("stray wait");
    property p_idle; !taken && hreadyout_o |=> hreadyout_o; endproperty
    a_idle: assert property (p_idle) else $error("idle wait");
    property p_hold; hreadyout_o ##1 hreadyout_o |-> $stable(hrdata_o);
    endproperty
    a_hold: assert property (p_hold) else $error("hrdata moved");
    property p_load; !$stable(hrdata_o) |-> !$past(hreadyout_o);
    endproperty
    a_load: assert property (p_load) else $error("hrdata early");
    property p_quiet;
        ($stable(trig_n_i) && !taken)[*6] |-> $stable(irq_o);
    endproperty
    a_quiet: assert property (p_quiet) else $error("irq moved");
    property p_mask; $rose(irq_o) |-> wrote_r; endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    c_write: cover property (taken && hwrite_i);
    c_irq: cover property ($rose(irq_o));
    c_trig: cover property (trig_n_i != '1);
endmodule
bind lppl_light_pen lppl_light_pen_props #(.NTRIG(NTRIG)) u_props (
    .clk_i(clk_i), .srst_i(srst_i), .trig_n_i(trig_n_i), .hsel_i(hsel_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .irq_o(irq_o));

// ### testbench/tb_top.sv
// Bench for the light pen position latch over AHB-Lite.
// Assumes a pen model on the trigger pins and static beam counters.
`timescale 1ns/1ns
module tb_top;
    import lppl_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic fire = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [3:0] sel = 4'h0;
    logic [7:0] width = 8'h00;
    logic [7:0] col = 8'h00;
    logic [7:0] row = 8'h00;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o, d;
    logic [3:0] trig_n;
    logic hreadyout_o, hresp_o, irq_o;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    lppl_pen_model u_pen (.clk_i(clk_i), .fire_i(fire), .sel_i(sel),
        .width_i(width), .trig_n_o(trig_n));
    lppl_light_pen u_dut (.clk_i(clk_i), .srst_i(srst_i), .trig_n_i(trig_n),
        .beam_column_i(col), .beam_row_i(row), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .irq_o(irq_o));
    initial forever #4 clk_i = ~clk_i;
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] wd);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        htrans_i <= 2'h2;
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        d = hrdata_o;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(d, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        xfer(1'b1, a, v);
    endtask
    task automatic pulse(input logic [3:0] s, input logic [7:0] w);
        sel <= s;
        width <= w;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 4; i++) begin
            rd(LPPL_OFS_TRIG_BASE + 8'(4 * i), 32'h1);
        end
        rd(LPPL_OFS_GFX_CTRL, 32'h0);
        col <= 8'he3;
        row <= 8'h9b;
        pulse(4'h2, 8'd16);
        repeat (20) @(posedge clk_i);
        rd(LPPL_OFS_COLUMN, 32'he3);
        rd(LPPL_OFS_ROW, 32'h9b);
        rd(LPPL_OFS_IRQ_STS, 32'h3);
        col <= 8'h10;
        row <= 8'h20;
        pulse(4'h1, 8'd200);
        repeat (8) @(posedge clk_i);
        col <= 8'h00;
        row <= 8'h00;
        repeat (8) @(posedge clk_i);
        rd(LPPL_OFS_COLUMN, 32'h10);
        rd(LPPL_OFS_TRIG_BASE, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        wr(LPPL_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        wr(LPPL_OFS_IRQ_STS, 32'h3);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        rd(LPPL_OFS_IRQ_STS, 32'h0);
        rd(LPPL_OFS_IRQ_MASK, 32'h1);
        repeat (200) @(posedge clk_i);
        rd(LPPL_OFS_ROW, 32'h20);
        rd(LPPL_OFS_TRIG_BASE, 32'h1);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        rd(LPPL_OFS_COLUMN, 32'h10);
        rd(LPPL_OFS_ROW, 32'h20);
        rd(LPPL_OFS_IRQ_MASK, 32'h0);
        wr(LPPL_OFS_GFX_CTRL, 32'h4);
        rd(LPPL_OFS_GFX_CTRL, 32'h4);
        pulse(4'h4, 8'd16);
        repeat (30) @(posedge clk_i);
        rd(LPPL_OFS_TRIG_BASE + 8'h08, 32'h0);
        rd(LPPL_OFS_TRIG_BASE, 32'h1);
        rd(LPPL_OFS_COLUMN, 32'h0);
        wr(LPPL_OFS_GFX_CTRL, 32'h0);
        rd(LPPL_OFS_TRIG_BASE + 8'h08, 32'h1);
        rd(8'h40, 32'h0);
        end_of_test();
    end
endmodule
